// file: hw/adccr_pkg.sv
// package of constants and types for the converter configuration and readout block
`default_nettype none
package adccr_pkg;
    // ****************************************
    // configuration word
    // ****************************************
    localparam int CFG_W = 12;
    localparam logic [11:0] CFG_RESET = 12'hFFF;
    localparam int B_AUTOCH = 11;
    localparam int B_CLKSRC = 10;
    localparam int B_TRIG = 9;
    localparam int B_RATE = 8;
    localparam int B_POL = 7;
    localparam int B_FUNC = 6;
    localparam int B_DIR = 5;
    localparam int B_ANAP = 4;
    localparam int B_NAP = 3;
    localparam int B_DEEP = 2;
    localparam int B_TAG = 1;
    localparam int B_SRST = 0;
    // ****************************************
    // commands and frame layout
    // ****************************************
    localparam logic [3:0] CMD_CH_LAST = 4'h7;
    localparam logic [3:0] CMD_WAKE = 4'hB;
    localparam logic [3:0] CMD_RDCFG = 4'hC;
    localparam logic [3:0] CMD_RDDATA = 4'hD;
    localparam logic [3:0] CMD_WRCFG = 4'hE;
    localparam logic [3:0] CMD_DEFAULT = 4'hF;
    localparam logic [4:0] CMD_LAST_EDGE = 5'h03;
    localparam logic [4:0] WORD_LAST_EDGE = 5'h0F;
    localparam int RES_W = 16;
    localparam int TAG_W = 3;
    localparam int TX_W = 24;
    // ****************************************
    // conversion timing in conversion clocks, clock periods in ns
    // ****************************************
    localparam logic [5:0] SAMPLE_CONVERSION_CLOCK = 6'h03;
    localparam logic [5:0] CONV_CONVERSION_CLOCK = 6'h12;
    localparam logic [5:0] CYCLE_FAST = 6'h15;
    localparam logic [5:0] CYCLE_SLOW = 6'h2A;
    localparam int CLK_NS = 10;
    localparam int OSC_NS = 40;
    localparam int OSC_CYC = (OSC_NS / CLK_NS) < 1 ? 1 : (OSC_NS / CLK_NS);
    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic sclk;
        logic frame_select_n;
        logic serial_input;
        logic convert_start_n;
        logic status_in;
    } adccr_pins_t;
    typedef enum logic {CV_ACQ, CV_CONV} adccr_cv_t;
endpackage
`default_nettype wire

// file: hw/adccr_core.sv
// converter configuration word, conversion sequencing and serial result readout
//
// Notes on behaviour
// (RULE_01) config read returns 4 result MSBs, config
// (RULE_02) config read ignores convert start, status idle
// (RULE_03) all config bits reset to one
// (RULE_04) config write lands on sixteenth falling edge
// (RULE_05) serial input sampled on falling clock edges
// (RULE_06) bit 11 auto-sequences channels
// (RULE_07) bit 10 picks serial-half or oscillator clock
// (RULE_08) bit 9 picks auto or manual trigger
// (RULE_09) bit 8 picks 21 or 42 clock cycle
// (RULE_10) bit 7 sets status polarity
// (RULE_11) bit 6 picks interrupt or end-of-conversion
// (RULE_12) bit 5 makes status pin chain input
// (RULE_13) bit 4 auto nap, ignored when 9,8 zero
// (RULE_14) bit 3 nap, wake command sets it
// (RULE_15) bit 2 deep sleep, wake command sets it
// (RULE_16) bit 1 appends channel tag bits
// (RULE_17) bit 0 zero resets, returns to one
// (RULE_18) result latched at end, shown at frame start
// (RULE_19) host avoids shifting around end of sampling
// (RULE_20) end of sampling: convert start or third clock; auto trigger at the 42 clock cycle ends it on the 24th clock
// (RULE_21) frame before end reads previous result
// (RULE_22) result MSB first, tag, then zeros
// (RULE_23) result coded straight binary
// (RULE_24) output driven only while frame selected
// (RULE_25) first frame after reset shifts all ones
// (RULE_26) host reads during conversion on shared clock
`default_nettype none
module adccr_core #(
    parameter int CHANNELS = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire adccr_pkg::adccr_pins_t pins,
    input wire logic [15:0] adc_code,
    output logic serial_output_r,
    output logic serial_oe_n_r,
    output logic status_out_r,
    output logic status_oe_n_r,
    output logic [2:0] chan_sel_r,
    output logic sampling_r,
    output logic nap_r,
    output logic deep_r,
    output logic [11:0] config_word_r
);
    import adccr_pkg::*;

    // ****************************************
    // serial interface state
    // ****************************************
    logic sclk_q_r, sclk_q_nxt, cs_q_r, cs_q_nxt, cv_q_r, cv_q_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [15:0] rx_r, rx_nxt;
    logic [TX_W-1:0] tx_r, tx_nxt;
    logic [11:0] cfg_nxt;
    logic rdcfg_r, rdcfg_nxt, first_r, first_nxt, int_r, int_nxt, srst_r, srst_nxt;
    logic sdo_nxt, sdo_oe_n_nxt, st_out_nxt, st_oe_n_nxt;
    logic sclk_fall, sclk_rise, cs_fall, cv_fall;
    logic [3:0] cmd;
    logic cmd_chan, cmd_wake, cmd_any;
    // conversion state
    adccr_cv_t cv_r, cv_nxt;
    logic [5:0] cv_cnt_r, cv_cnt_nxt;
    logic [7:0] osc_r, osc_nxt;
    logic half_r, half_nxt, conversion_clock_en, eoc_r, eoc_nxt, anap_r, anap_nxt, pd;
    logic [RES_W-1:0] result_r, result_nxt;
    logic [2:0] tag_r, tag_nxt, chan_nxt;
    logic [5:0] acq_len;
    logic st_active;

    // edge detection on the synchronous pins
    assign sclk_fall = sclk_q_r & ~pins.sclk;
    assign sclk_rise = ~sclk_q_r & pins.sclk;
    assign cs_fall = cs_q_r & ~pins.frame_select_n;
    assign cv_fall = cv_q_r & ~pins.convert_start_n;
    assign cmd = {rx_r[2:0], pins.serial_input};

    // frame decode, configuration word and output shifter
    always_comb begin
        sclk_q_nxt = pins.sclk;
        cs_q_nxt = pins.frame_select_n;
        cv_q_nxt = pins.convert_start_n;
        cnt_nxt = cnt_r;
        rx_nxt = rx_r;
        tx_nxt = tx_r;
        cfg_nxt = config_word_r;
        rdcfg_nxt = rdcfg_r;
        first_nxt = first_r;
        srst_nxt = 1'b0;
        cmd_chan = 1'b0;
        cmd_wake = 1'b0;
        cmd_any = 1'b0;
        // set wins over the frame-start clear
        int_nxt = eoc_r | (int_r & ~cs_fall);
        if (cs_fall) begin
            cnt_nxt = 5'h00;
            rx_nxt = 16'h0000;
            rdcfg_nxt = 1'b0;
            first_nxt = 1'b0;
            if (first_r) begin
                tx_nxt = {TX_W{1'b1}}; // RULE_25
            end else begin
                // RULE_18 RULE_21 RULE_22 RULE_23 RULE_16
                tx_nxt = {result_r, (config_word_r[B_TAG] ? tag_r : 3'h0), 5'h00};
            end
        end else if (!pins.frame_select_n && sclk_fall) begin
            rx_nxt = {rx_r[14:0], pins.serial_input}; // RULE_05
            // chain data follows the local word when the pin is an input
            tx_nxt = {tx_r[TX_W-2:0], ~config_word_r[B_DIR] & pins.status_in}; // RULE_12
            if (cnt_r != 5'h1F) begin
                cnt_nxt = cnt_r + 5'h01;
            end
            if (cnt_r == CMD_LAST_EDGE) begin
                cmd_any = (cmd <= CMD_CH_LAST) || (cmd == CMD_WAKE) || (cmd == CMD_DEFAULT);
                cmd_chan = (cmd <= CMD_CH_LAST);
                if (cmd == CMD_WAKE) begin
                    cmd_wake = 1'b1;
                    cfg_nxt[B_NAP] = 1'b1; // RULE_14
                    cfg_nxt[B_DEEP] = 1'b1; // RULE_15
                end
                if (cmd == CMD_DEFAULT) begin
                    cfg_nxt = CFG_RESET; // RULE_03
                end
                if (cmd == CMD_RDCFG) begin
                    rdcfg_nxt = 1'b1; // RULE_02
                    tx_nxt = {config_word_r, 12'h000}; // RULE_01
                end
            end
            if (cnt_r == WORD_LAST_EDGE && rx_r[14:11] == CMD_WRCFG) begin
                cfg_nxt = {rx_r[10:0], pins.serial_input}; // RULE_04
                if (!pins.serial_input) begin
                    // bit 0 low: reset the system, word back to defaults
                    cfg_nxt = CFG_RESET; // RULE_17
                    srst_nxt = 1'b1;
                    first_nxt = 1'b1;
                end
            end
        end
        // output driven only inside the frame; once data runs out, low, or chain data when the status pin is an input
        sdo_oe_n_nxt = pins.frame_select_n; // RULE_24
        sdo_nxt = pins.frame_select_n ? 1'b0 : tx_nxt[TX_W-1]; // RULE_22
        // status pin: level end-of-conversion or sticky interrupt
        st_active = config_word_r[B_FUNC] ? (cv_r == CV_ACQ) : int_r; // RULE_11
        if (rdcfg_r) begin
            st_active = 1'b0; // RULE_02
        end
        st_out_nxt = st_active ^ config_word_r[B_POL]; // RULE_10
        st_oe_n_nxt = ~config_word_r[B_DIR]; // RULE_12
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclk_q_r <= 1'b1; // clock idles high, so no false rise after reset
            cs_q_r <= 1'b1;
            cv_q_r <= 1'b1;
            cnt_r <= 5'h00;
            rx_r <= 16'h0000;
            tx_r <= {TX_W{1'b1}};
            config_word_r <= CFG_RESET; // RULE_03
            rdcfg_r <= 1'b0;
            first_r <= 1'b1;
            int_r <= 1'b0;
            srst_r <= 1'b0;
            serial_output_r <= 1'b0;
            serial_oe_n_r <= 1'b1;
            status_out_r <= 1'b0;
            status_oe_n_r <= 1'b0;
        end else begin
            sclk_q_r <= sclk_q_nxt;
            cs_q_r <= cs_q_nxt;
            cv_q_r <= cv_q_nxt;
            cnt_r <= cnt_nxt;
            rx_r <= rx_nxt;
            tx_r <= tx_nxt;
            config_word_r <= cfg_nxt;
            rdcfg_r <= rdcfg_nxt;
            first_r <= first_nxt;
            int_r <= int_nxt;
            srst_r <= srst_nxt;
            serial_output_r <= sdo_nxt;
            serial_oe_n_r <= sdo_oe_n_nxt;
            status_out_r <= st_out_nxt;
            status_oe_n_r <= st_oe_n_nxt;
        end
    end

    // ****************************************
    // conversion sequencer
    // ****************************************
    // conversion clock: every second serial rise, or the oscillator divider
    assign conversion_clock_en = config_word_r[B_CLKSRC] ? (osc_r == 8'(OSC_CYC - 1)) // RULE_07
                                             : (sclk_rise & half_r);
    // auto cycle length minus the conversion part
    assign acq_len = config_word_r[B_RATE] ? (CYCLE_SLOW - CONV_CONVERSION_CLOCK) // RULE_09
                                           : (CYCLE_FAST - CONV_CONVERSION_CLOCK);
    assign pd = ~config_word_r[B_NAP] | ~config_word_r[B_DEEP] | anap_r;

    // sampling, conversion, end of conversion and channel stepping
    always_comb begin
        cv_nxt = cv_r;
        cv_cnt_nxt = cv_cnt_r;
        osc_nxt = (osc_r == 8'(OSC_CYC - 1)) ? 8'h00 : osc_r + 8'h01;
        half_nxt = sclk_rise ? ~half_r : half_r;
        eoc_nxt = 1'b0;
        anap_nxt = anap_r;
        result_nxt = result_r;
        tag_nxt = tag_r;
        chan_nxt = chan_sel_r;
        if (cmd_chan) begin
            chan_nxt = cmd[2:0];
        end
        if (cmd_any || cmd_wake) begin
            anap_nxt = 1'b0;
        end
        unique case (cv_r)
            CV_ACQ: begin
                if (config_word_r[B_TRIG]) begin
                    // manual: convert start fall ends sampling
                    if (cv_fall && !rdcfg_r && !(pd && !anap_r)) begin // RULE_02
                        cv_nxt = CV_CONV; // RULE_08 RULE_20
                        cv_cnt_nxt = 6'h00;
                        anap_nxt = 1'b0;
                    end
                end else if (!pd && conversion_clock_en) begin
                    // auto: sampling ends after the set number of clocks
                    if (cv_cnt_r >= acq_len - 6'h01) begin
                        cv_nxt = CV_CONV; // RULE_08 RULE_20
                        cv_cnt_nxt = 6'h00;
                    end else begin
                        cv_cnt_nxt = cv_cnt_r + 6'h01;
                    end
                end
            end
            CV_CONV: begin
                if (conversion_clock_en) begin
                    if (cv_cnt_r == CONV_CONVERSION_CLOCK - 6'h01) begin
                        cv_nxt = CV_ACQ;
                        cv_cnt_nxt = 6'h00;
                        eoc_nxt = 1'b1;
                        result_nxt = adc_code; // RULE_18 RULE_23
                        tag_nxt = chan_sel_r;
                        if (config_word_r[B_AUTOCH]) begin
                            chan_nxt = (32'(chan_sel_r) == CHANNELS - 1) ? 3'h0 // RULE_06
                                                                         : chan_sel_r + 3'h1;
                        end
                        // auto nap only counts when trigger and rate bits allow it
                        anap_nxt = ~config_word_r[B_ANAP] // RULE_13
                                   & (config_word_r[B_TRIG] | config_word_r[B_RATE]);
                    end else begin
                        cv_cnt_nxt = cv_cnt_r + 6'h01;
                    end
                end
            end
        endcase
        if (srst_r) begin
            cv_nxt = CV_ACQ; // RULE_17
            cv_cnt_nxt = 6'h00;
            anap_nxt = 1'b0;
            chan_nxt = 3'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cv_r <= CV_ACQ;
            cv_cnt_r <= 6'h00;
            osc_r <= 8'h00;
            half_r <= 1'b0;
            eoc_r <= 1'b0;
            anap_r <= 1'b0;
            result_r <= 16'h0000;
            tag_r <= 3'h0;
            chan_sel_r <= 3'h0;
            sampling_r <= 1'b1;
            nap_r <= 1'b0;
            deep_r <= 1'b0;
        end else begin
            cv_r <= cv_nxt;
            cv_cnt_r <= cv_cnt_nxt;
            osc_r <= osc_nxt;
            half_r <= half_nxt;
            eoc_r <= eoc_nxt;
            anap_r <= anap_nxt;
            result_r <= result_nxt;
            tag_r <= tag_nxt;
            chan_sel_r <= chan_nxt;
            sampling_r <= (cv_nxt == CV_ACQ);
            nap_r <= ~cfg_nxt[B_NAP] | anap_nxt; // RULE_14 RULE_13
            deep_r <= ~cfg_nxt[B_DEEP]; // RULE_15
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    cfg_write_a: assert property ( // RULE_04
        (!pins.frame_select_n && sclk_fall && cnt_r == WORD_LAST_EDGE
         && rx_r[14:11] == CMD_WRCFG && pins.serial_input)
        |=> config_word_r == $past(rx_nxt[11:0])) else $error("config write lost");
    soft_reset_a: assert property ( // RULE_17
        srst_r |-> config_word_r == CFG_RESET && first_r ##1 cv_r == CV_ACQ)
        else $error("soft reset incomplete");
    sdo_float_a: assert property ( // RULE_24
        pins.frame_select_n |=> serial_oe_n_r) else $error("output driven outside frame");
    rdcfg_quiet_a: assert property ( // RULE_02
        rdcfg_r && !config_word_r[B_FUNC] |=> status_out_r == $past(config_word_r[B_POL]))
        else $error("status active during config read");
    first_ones_a: assert property ( // RULE_25
        cs_fall && first_r |=> tx_r == {TX_W{1'b1}} && !first_r)
        else $error("first frame not all ones");
    eoc_load_a: assert property ( // RULE_18
        eoc_r |-> result_r == $past(adc_code) && cv_r == CV_ACQ)
        else $error("result not latched at end");
    conv_end_a: assert property ( // RULE_08
        cv_r == CV_CONV && conversion_clock_en && cv_cnt_r == CONV_CONVERSION_CLOCK - 6'h01 |=> eoc_r ##1 !eoc_r)
        else $error("end of conversion misplaced");
    manual_start_a: assert property ( // RULE_20
        cv_r == CV_ACQ && config_word_r[B_TRIG] && cv_fall && !rdcfg_r && !pd && !srst_r
        |=> cv_r == CV_CONV && cv_cnt_r == 6'h00) else $error("manual start missed");
    wake_bits_a: assert property ( // RULE_14
        cmd_wake |=> config_word_r[B_NAP] && config_word_r[B_DEEP])
        else $error("wake did not restore bits");
endmodule
`default_nettype wire

// file: tb/adccr_host.sv
// host model: serial bus master driving frame select, serial clock and data
`default_nettype none
module adccr_host (
    input wire logic clk,
    input wire logic ser_out,
    input wire logic ser_oe_n,
    output logic sclk,
    output logic frame_n,
    output logic ser_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle: clock parked high and still, frame closed
    initial begin
        sclk = 1'b1;
        frame_n = 1'b1;
        ser_in = 1'b0;
    end
    // one frame msb first; each bit is read just before the fall that ends it
    task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx);
        rx = 24'h000000;
        @(negedge clk) frame_n = 1'b0;
        repeat (3) @(negedge clk);
        for (int i = 0; i < n; i++) begin
            ser_in = tx[23 - i];
            rx[23 - i] = ser_oe_n ? ~ser_out : ser_out; // released line is garbage
            sclk = 1'b0;
            repeat (2) @(negedge clk);
            sclk = 1'b1;
            repeat (2) @(negedge clk);
        end
        frame_n = 1'b1;
        ser_in = ~ser_in; // input line not held between frames
        repeat (2) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// testbench for the converter configuration and readout block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import adccr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cv_n = 1'b1;
    logic chain = 1'b0;
    logic [15:0] code = 16'h0000;
    logic sclk, frame_n, ser_in, ser_out, ser_oe_n, st_out, st_oe_n, samp, nap, deep;
    logic [2:0] chan;
    logic [11:0] cfg;
    logic [23:0] rx;
    adccr_pins_t pins;
    int n_mismatch = 0;
    int n_compared = 0;
    // ****************************************
    // clock, pins and instances
    // ****************************************
    always #5 clk = ~clk;
    // status pin wire: the block drives it unless it is a chain input
    assign pins = '{sclk: sclk, frame_select_n: frame_n, serial_input: ser_in,
        convert_start_n: cv_n, status_in: st_oe_n ? chain : st_out};
    adccr_host i_host (.clk(clk), .ser_out(ser_out), .ser_oe_n(ser_oe_n), .sclk(sclk),
        .frame_n(frame_n), .ser_in(ser_in));
    adccr_core i_dut (.clk(clk), .rst_n(rst_n), .pins(pins), .adc_code(code),
        .serial_output_r(ser_out), .serial_oe_n_r(ser_oe_n), .status_out_r(st_out),
        .status_oe_n_r(st_oe_n), .chan_sel_r(chan), .sampling_r(samp), .nap_r(nap),
        .deep_r(deep), .config_word_r(cfg));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // wait for the sampling flag to reach v, counting cycles
    task automatic wait_samp(input logic v, output int k);
        k = 0;
        while (samp !== v && k < 400) begin
            @(negedge clk);
            k++;
        end
        cmp(24'(samp), 24'(v));
    endtask
    task automatic xf(input logic [23:0] tx, input int n);
        i_host.xfer(tx, n, rx);
    endtask
    // in auto trigger a frame starts just after sampling ends, inside conversion
    task automatic wcfg(input logic [11:0] v);
        int k;
        if (cfg[B_TRIG] === 1'b0) begin
            wait_samp(1'b1, k);
            wait_samp(1'b0, k);
        end
        xf({CMD_WRCFG, v, 8'h00}, 16);
    endtask
    task automatic pulse_cv;
        cv_n = 1'b0;
        @(negedge clk) cv_n = 1'b1;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        cmp(24'(cfg), 24'hFFF);
        cmp(24'(ser_oe_n), 24'h1);
        xf({CMD_RDDATA, 20'h0}, 16);
        cmp(rx, 24'hFFFF00);
        cmp(24'(ser_oe_n), 24'h1);
    endtask
    task automatic t_write;
        xf({CMD_WRCFG, 12'h123, 8'h00}, 15);
        cmp(24'(cfg), 24'hFFF);
        wcfg(12'hA5F);
        cmp(24'(cfg), 24'hA5F);
        cmp(24'(st_oe_n), 24'h1);
    endtask
    task automatic t_manual;
        int k;
        wcfg(12'h77F);
        cmp(24'(st_out), 24'h1);
        wcfg(12'h7BF);
        cmp(24'(st_out), 24'h1);
        xf({4'h5, 20'h0}, 4);
        cmp(24'(chan), 24'h5);
        code = 16'h8000;
        pulse_cv();
        wait_samp(1'b0, k);
        wait_samp(1'b1, k);
        // interrupt flag is set one clock after the end and shown one clock later
        repeat (2) @(negedge clk);
        cmp(24'(st_out), 24'h0);
        xf({CMD_RDDATA, 20'h0}, 24);
        cmp(rx, 24'h8000A0);
        cmp(24'(st_out), 24'h1);
        code = 16'h7FFF;
        pulse_cv();
        repeat (2) @(negedge clk);
        xf({CMD_RDDATA, 20'h0}, 16);
        cmp(rx, 24'h800000);
        wait_samp(1'b1, k);
        xf({CMD_RDDATA, 20'h0}, 16);
        cmp(rx, 24'h7FFF00);
    endtask
    // convert start pulsed between two falls while the config is read back
    task automatic t_cfgread;
        fork
            xf({CMD_RDCFG, 20'h0}, 16);
            begin
                repeat (42) @(negedge clk);
                pulse_cv();
            end
        join
        cmp(rx, 24'h77BF00);
        repeat (30) @(negedge clk);
        cmp(24'(samp), 24'h1);
        cmp(24'(st_out), 24'h1);
    endtask
    task automatic t_power;
        wcfg(12'h7B3);
        cmp(24'({nap, deep}), 24'h3);
        code = 16'h1234;
        pulse_cv();
        repeat (10) @(negedge clk);
        xf({CMD_WAKE, 20'h0}, 4);
        cmp(24'(cfg), 24'h7BF);
        cmp(24'({nap, deep}), 24'h0);
        xf({CMD_RDDATA, 20'h0}, 16);
        cmp(rx, 24'h7FFF00);
    endtask
    // auto trigger: cycles from one sampling start to the next
    task automatic t_period(input logic [11:0] v, input int cyc);
        int k0;
        int k1;
        logic [2:0] c0;
        wcfg(v);
        wait_samp(1'b0, k0);
        wait_samp(1'b1, k0);
        c0 = chan;
        wait_samp(1'b0, k0);
        wait_samp(1'b1, k1);
        cmp(24'(k0 + k1), 24'(cyc * OSC_CYC));
        // channel wraps within three bits
        cmp(24'(chan), 24'(3'(c0 + 3'h1)));
        cmp(24'(nap), 24'h0);
    endtask
    task automatic t_soft;
        wcfg(12'hFFE);
        cmp(24'(cfg), 24'hFFF);
        xf({CMD_RDDATA, 20'h0}, 16);
        cmp(rx, 24'hFFFF00);
        wcfg(12'h7FF);
        xf({CMD_DEFAULT, 20'h0}, 4);
        cmp(24'(cfg), 24'hFFF);
        // external reset in mid-run with the frame closed
        wcfg(12'h7FF);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        cmp(24'(cfg), 24'hFFF);
        cmp(24'(ser_oe_n), 24'h1);
        xf({CMD_RDDATA, 20'h0}, 16);
        cmp(rx, 24'hFFFF00);
    endtask
    // main sequence
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        t_reset();
        t_write();
        t_manual();
        t_cfgread();
        t_power();
        t_period(12'hCFF, 21);
        t_period(12'hDFF, 42);
        t_period(12'hCEF, 21);
        t_soft();
        test_done();
    end
    // watchdog: the tests need under a fifth of this span
    initial begin
        #200000;
        n_mismatch++;
        test_done();
    end
endmodule
`default_nettype wire
